// ===== design/sach_pkg.sv
/*
 * constants shared by the conversion host controller.
 * assumes a 100 MHz system clock.
 */
package sach_pkg;
    localparam int  CLK_PERIOD_NS    = 10;
    localparam int  RESULT_W         = 14;
    localparam int  PULSE_MIN_NS     = 175;
    localparam int  PULSE_NOM_NS     = 200;
    localparam int  PULSE_MAX_NS     = 225;
    localparam int  LOW_MIN_NS       = 50;
    localparam int  DATA_VALID_NS    = 35;
    localparam int  PERIOD_FULL_NS   = 2000;
    localparam int  PERIOD_CAL_NS    = 5000;
    localparam int  PULSE_CYC        = PULSE_NOM_NS / CLK_PERIOD_NS;
    localparam int  PULSE_MIN_CYC    =
        (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  PULSE_MAX_CYC    = PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam int  LOW_MIN_CYC      =
        (LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  DATA_WAIT_CYC    =
        (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  PERIOD_FULL_CYC  = PERIOD_FULL_NS / CLK_PERIOD_NS;
    localparam int  PERIOD_CAL_CYC   = PERIOD_CAL_NS / CLK_PERIOD_NS;
    localparam logic [RESULT_W-1:0] CODE_MIDSCALE = 14'h2000;
    localparam logic [RESULT_W-1:0] CODE_FULL     = 14'h3FFF;
    localparam logic [RESULT_W-1:0] CODE_NEG_FS   = 14'h0000;
    typedef enum logic [1:0] {
        SACH_IDLE  = 2'b00,
        SACH_PULSE = 2'b01,
        SACH_BUSY  = 2'b10,
        SACH_SETTL = 2'b11
    } sach_state_e;
endpackage

// ===== design/sach_rate_div.sv
/*
 * rate divider: one-cycle tick every period_cyc clocks.
 * assumes period_cyc is held steady while enabled.
 */
`timescale 1ns/1ps
`default_nettype none
module sach_rate_div #(
    parameter int CNT_W = 16
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] period_cyc,
    output logic                  tick
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!enable) begin
            cnt_nxt = '0;
        end else if (cnt_r >= period_cyc - 1'b1) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== design/sach_host.sv
/*
 * host controller driving start pulses to a pulse-triggered sampling
 * converter and capturing its offset-binary result word.
 * assumes converter outputs are synchronous to clock (100 MHz).
 */
`timescale 1ns/1ps
`default_nettype none
// What this block and its converter do
// RULE_01 - converter holds end-of-conversion high while converting
// RULE_02 - premature start spoils the aborted and the next results
// RULE_03 - start a new pulse only while end-of-conversion is low
// RULE_04 - converter acts on both start edges, so width matters
// RULE_05 - at full rate start pulse stays between 175 and 225 ns
// RULE_06 - keep start low at least 50 ns between pulses
// RULE_07 - nominal drive is 500 kHz with 200 ns wide pulses
// RULE_08 - keep converting continuously throughout warmup
// RULE_09 - result is 14-bit offset binary, midscale means zero
// RULE_10 - offset point: msb one, rest zero, lsb toggling
// RULE_11 - gain point: all ones with lsb toggling
// RULE_12 - calibration runs continuous conversions at reduced rate
// RULE_13 - capture result only after the eoc falling edge delay
module sach_host
    import sach_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int FULL_PERIOD  = PERIOD_FULL_CYC,
    parameter int CAL_PERIOD   = PERIOD_CAL_CYC
) (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                run_enable,
    input  wire logic                warmup,
    input  wire logic                cal_mode,
    input  wire logic                eoc,
    input  wire logic [RESULT_W-1:0] adc_data,
    output logic                     start_conv,
    output logic [RESULT_W-1:0]      result,
    output logic                     result_valid,
    output logic                     result_bad,
    output logic                     is_offset_pt,
    output logic                     is_gain_pt,
    output logic [RESULT_W-1:0]      result_signed
);
    if (PULSE_CYCLES < PULSE_MIN_CYC ||
        PULSE_CYCLES > PULSE_MAX_CYC) begin : g_chk_pulse
        $error("pulse width outside the allowed window");
    end
    if (FULL_PERIOD < PULSE_CYCLES + LOW_MIN_CYC + 2) begin : g_chk_full
        $error("full period too short");
    end
    if (CAL_PERIOD < FULL_PERIOD || CAL_PERIOD >= 65536) begin : g_chk_cal
        $error("calibration period out of range");
    end

    sach_state_e         state_r, state_nxt;
    logic [7:0]          wcnt_r, wcnt_nxt;
    logic                start_r, start_nxt;
    logic [RESULT_W-1:0] res_r, res_nxt;
    logic                val_r, val_nxt;
    logic                bad_r, bad_nxt;
    logic                taint_r, taint_nxt;
    logic                offp_r, offp_nxt;
    logic                gainp_r, gainp_nxt;
    logic [RESULT_W-1:0] sgn_r, sgn_nxt;
    logic                eoc_d_r;
    logic                go;
    logic                tick;
    logic [15:0]         period;
    logic [7:0]          hi_run_r, hi_run_nxt;
    logic [15:0]         idle_run_r, idle_run_nxt;

    assign go     = run_enable | warmup | cal_mode; // RULE_08 RULE_12
    assign period = cal_mode ? 16'(CAL_PERIOD) : 16'(FULL_PERIOD); // RULE_12

    sach_rate_div #(
        .CNT_W (16)
    ) u_div (
        .clock      (clock),
        .reset_n    (reset_n),
        .enable     (go),
        .period_cyc (period),
        .tick       (tick)
    );

    always_comb begin
        state_nxt = state_r;
        wcnt_nxt  = wcnt_r;
        start_nxt = start_r;
        res_nxt   = res_r;
        val_nxt   = 1'b0;
        bad_nxt   = bad_r;
        taint_nxt = taint_r;
        offp_nxt  = offp_r;
        gainp_nxt = gainp_r;
        sgn_nxt   = sgn_r;
        // checker helpers: start high run and idle wait during warmup
        hi_run_nxt   = start_r ? hi_run_r + 8'h01 : 8'h00;
        idle_run_nxt = 16'h0000;
        if (warmup && state_r == SACH_IDLE && !eoc) begin
            idle_run_nxt = idle_run_r + 16'h0001;
        end
        case (state_r)
            SACH_IDLE: begin
                // only issue a start while conversion is not in progress
                if (tick && !eoc) begin // RULE_03
                    start_nxt = 1'b1;
                    wcnt_nxt  = 8'(PULSE_CYCLES - 1);
                    state_nxt = SACH_PULSE;
                end else if (tick && eoc) begin
                    taint_nxt = 1'b1; // RULE_02
                end
            end
            SACH_PULSE: begin
                // both edges matter, width held exact
                if (wcnt_r == 8'h00) begin // RULE_04 RULE_05 RULE_07
                    start_nxt = 1'b0;
                    state_nxt = SACH_BUSY;
                end else begin
                    wcnt_nxt = wcnt_r - 8'h01;
                end
            end
            SACH_BUSY: begin
                if (eoc_d_r && !eoc) begin // RULE_13
                    wcnt_nxt  = 8'(DATA_WAIT_CYC);
                    state_nxt = SACH_SETTL;
                end
            end
            SACH_SETTL: begin
                if (wcnt_r == 8'h00) begin // RULE_13
                    res_nxt   = adc_data; // RULE_09
                    val_nxt   = 1'b1;
                    bad_nxt   = taint_r; // RULE_01 RULE_02
                    taint_nxt = 1'b0;
                    offp_nxt  = adc_data == CODE_MIDSCALE ||
                                adc_data == (CODE_MIDSCALE | 14'h0001); // RULE_10
                    gainp_nxt = adc_data == CODE_FULL ||
                                adc_data == (CODE_FULL & 14'h3FFE); // RULE_11
                    sgn_nxt   = adc_data ^ CODE_MIDSCALE; // RULE_09
                    state_nxt = SACH_IDLE;
                end else begin
                    wcnt_nxt = wcnt_r - 8'h01;
                end
            end
            default: state_nxt = SACH_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= SACH_IDLE;
            wcnt_r  <= 8'h00;
            start_r <= 1'b0;
            res_r   <= CODE_NEG_FS;
            val_r   <= 1'b0;
            bad_r   <= 1'b0;
            taint_r <= 1'b0;
            offp_r  <= 1'b0;
            gainp_r <= 1'b0;
            sgn_r   <= CODE_NEG_FS;
            eoc_d_r <= 1'b0;
            hi_run_r   <= 8'h00;
            idle_run_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            wcnt_r  <= wcnt_nxt;
            start_r <= start_nxt;
            res_r   <= res_nxt;
            val_r   <= val_nxt;
            bad_r   <= bad_nxt;
            taint_r <= taint_nxt;
            offp_r  <= offp_nxt;
            gainp_r <= gainp_nxt;
            sgn_r   <= sgn_nxt;
            eoc_d_r <= eoc;
            hi_run_r   <= hi_run_nxt;
            idle_run_r <= idle_run_nxt;
        end
    end

    assign start_conv    = start_r;
    assign result        = res_r;
    assign result_valid  = val_r;
    assign result_bad    = bad_r;
    assign is_offset_pt  = offp_r;
    assign is_gain_pt    = gainp_r;
    assign result_signed = sgn_r;

    a_pulse_width: assert property ( // RULE_05
        @(posedge clock) disable iff (!reset_n)
        $fell(start_r) |-> hi_run_r == 8'(PULSE_CYCLES))
        else $error("start pulse width wrong");
    a_low_gap: assert property ( // RULE_06
        @(posedge clock) disable iff (!reset_n)
        $fell(start_r) |-> !start_r [*5])
        else $error("start low time too short");
    a_no_retrig: assert property ( // RULE_03
        @(posedge clock) disable iff (!reset_n)
        $rose(start_r) |-> $past(!eoc))
        else $error("start issued during conversion");
    a_capture_wait: assert property ( // RULE_13
        @(posedge clock) disable iff (!reset_n)
        (eoc_d_r && !eoc && state_r == SACH_BUSY) |-> !val_r [*6] ##1 val_r)
        else $error("result captured at wrong time");
    a_sign_map: assert property ( // RULE_09
        @(posedge clock) disable iff (!reset_n)
        val_r |-> (sgn_r == (res_r ^ 14'h2000)))
        else $error("signed result mismatch");
    a_offset_pt: assert property ( // RULE_10
        @(posedge clock) disable iff (!reset_n)
        val_r |-> (offp_r == (res_r[13:1] == 13'h1000)))
        else $error("offset point flag wrong");
    a_gain_pt: assert property ( // RULE_11
        @(posedge clock) disable iff (!reset_n)
        val_r |-> (gainp_r == (res_r[13:1] == 13'h1FFF)))
        else $error("gain point flag wrong");
    a_bad_taint: assert property ( // RULE_02
        @(posedge clock) disable iff (!reset_n)
        (state_r == SACH_SETTL && wcnt_r == 8'h00 && taint_r)
        |=> (val_r && bad_r))
        else $error("tainted result not flagged");
    // idle wait under warmup never outlasts the slowest tick period
    a_keep_running: assert property ( // RULE_08
        @(posedge clock) disable iff (!reset_n)
        idle_run_r <= 16'(CAL_PERIOD))
        else $error("conversions paused during warmup");
endmodule
`default_nettype wire

// ===== sim/sach_conv_model.sv
/* converter model: eoc and a result word for each start pulse.
   assumes start_conv, code and conv_cyc change off the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sach_conv_model
    import sach_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                start_conv,
    input  wire logic [RESULT_W-1:0] code,
    input  wire logic [7:0]          conv_cyc,
    output logic                     eoc,
    output logic [RESULT_W-1:0]      adc_data
);
    logic                st_q;
    logic [7:0]          cnt;
    logic [7:0]          len;
    logic [2:0]          dly;
    logic [RESULT_W-1:0] word;
    always @(posedge clock) begin
        st_q <= start_conv;
        if (!reset_n) begin
            eoc <= 1'b0;
            cnt <= 8'h00;
            dly <= 3'h0;
            adc_data <= 14'h0000;
        end else if (start_conv && !st_q) begin
            eoc <= 1'b1;
            word <= code;
            len <= conv_cyc;
            cnt <= 8'h00;
            adc_data <= ~adc_data;
        end else if (eoc) begin
            adc_data <= ~adc_data;
            if (!start_conv) begin
                cnt <= cnt + 8'h01;
            end
            if (!start_conv && cnt == len) begin
                eoc <= 1'b0;
                dly <= 3'h2;
            end
        end else if (dly != 3'h0) begin
            dly <= dly - 3'h1;
            adc_data <= (dly == 3'h1) ? word : ~adc_data;
        end
    end
endmodule
`default_nettype wire

// ===== sim/sach_host_bench.sv
/* self-checking bench for the conversion host controller.
   assumes the converter model beside it and shortened periods. */
`timescale 1ns/1ps
`default_nettype none
module sach_host_bench
    import sach_pkg::*;
;
    logic                clock, reset_n, run_enable, warmup, cal_mode;
    logic                eoc, start_conv, result_valid, result_bad;
    logic                is_offset_pt, is_gain_pt, prev_st, exp_bad;
    logic                exp_slow;
    logic [RESULT_W-1:0] adc_data, result, result_signed, code, exp_code;
    logic [7:0]          conv_cyc;
    logic [31:0]         lfsr_r;
    int                  failures, n_checks, cycles, since, exp_per;
    int                  hi_cnt, lo_cnt, n_res, slow_left, per_chk;
    logic [RESULT_W-1:0] corner[$];
    sach_host #(.FULL_PERIOD(40), .CAL_PERIOD(60)) sach_host_inst (
        .clock(clock), .reset_n(reset_n), .run_enable(run_enable),
        .warmup(warmup), .cal_mode(cal_mode), .eoc(eoc),
        .adc_data(adc_data), .start_conv(start_conv), .result(result),
        .result_valid(result_valid), .result_bad(result_bad),
        .is_offset_pt(is_offset_pt), .is_gain_pt(is_gain_pt),
        .result_signed(result_signed));
    sach_conv_model sach_conv_model_inst (
        .clock(clock), .reset_n(reset_n), .start_conv(start_conv),
        .code(code), .conv_cyc(conv_cyc), .eoc(eoc), .adc_data(adc_data));
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic run_test(input logic [2:0] mode, input int per, n);
        int t;
        per_chk = 0;
        exp_per = per;
        n_res = 0;
        {run_enable, warmup, cal_mode} = mode;
        for (t = 0; t < 5000 && n_res < n; t++) @(negedge clock);
        check(n_res >= n, 1'b1);
        {run_enable, warmup, cal_mode} = 3'b000;
        repeat (100) @(negedge clock);
        $display("test mode=%b done, results=%0d", mode, n_res);
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        cycles++;
        since++;
        if (cycles > 20000) begin
            failures++;
            complete_run();
        end
        if (!reset_n) begin
            per_chk = 0;
            lo_cnt = 99;
        end else if (start_conv && !prev_st) begin
            check(eoc, 1'b0);
            check(lo_cnt >= LOW_MIN_CYC, 1'b1);
            if (per_chk) check(since, exp_slow ? 3 * exp_per : exp_per);
            per_chk = 1;
            since = 0;
            hi_cnt = 1;
            exp_code = code;
            exp_slow = (conv_cyc == 8'h3C);
            // a tick refused during a slow conversion never spoils a word
            exp_bad = 1'b0;
        end else if (start_conv) begin
            hi_cnt++;
        end else if (prev_st) begin
            check(hi_cnt, PULSE_CYC);
            lo_cnt = 1;
        end else begin
            lo_cnt++;
        end
        if (reset_n && result_valid) begin
            check(result, exp_code);
            check(result_signed, exp_code ^ 14'h2000);
            check(is_offset_pt, exp_code[13:1] == 13'h1000);
            check(is_gain_pt, exp_code[13:1] == 13'h1FFF);
            check(result_bad, exp_bad);
            n_res++;
            lfsr_r = lfsr_next(lfsr_r);
            code = corner.size() > 0 ? corner.pop_front() : lfsr_r[13:0];
            conv_cyc = (slow_left > 0) ? 8'h3C : 8'h04;
            if (slow_left > 0) slow_left--;
        end
        prev_st = start_conv;
    end
    initial begin
        {reset_n, run_enable, warmup, cal_mode, prev_st} = 5'h00;
        {failures, n_checks, cycles, since, hi_cnt, slow_left} = 0;
        code = 14'h1555;
        conv_cyc = 8'h04;
        lfsr_r = 32'h9534;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        run_test(3'b100, 40, 12);
        corner = '{14'h2000, 14'h2001, 14'h3FFF, 14'h3FFE, 14'h0000};
        run_test(3'b101, 60, 8);
        run_test(3'b010, 40, 8);
        slow_left = 2;
        run_test(3'b100, 40, 6);
        per_chk = 0;
        run_enable = 1'b1;
        repeat (45) @(negedge clock);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        check({start_conv, result_valid, result_bad, result}, 32'h0);
        run_enable = 1'b0;
        reset_n = 1'b1;
        run_test(3'b100, 40, 4);
        complete_run();
    end
endmodule
`default_nettype wire
